// file: rtl/rws_params.svh
// Constants for the reset, watchdog and suspend sequencer
`ifndef RWS_PARAMS_SVH
`define RWS_PARAMS_SVH
`define RWS_CLK_HZ 40000000
`define RWS_ADDR_BUSRST_IE 8'h20
`define RWS_ADDR_WDOG_RESTART 8'h26
`define RWS_ADDR_PSC 8'hff
`define RWS_PSC_RUN 0
`define RWS_PSC_IES 2
`define RWS_PSC_SUSPEND 3
`define RWS_PSC_POR 4
`define RWS_PSC_WDR 6
`define RWS_PSC_POR_VALUE 8'h11
`define RWS_PSC_WDR_VALUE 8'h41
`define RWS_BUSRST_IE_BIT 0
`define RWS_RESET_VECTOR 14'h0000
`define RWS_STACK_RESET 8'h00
`define RWS_T_NOINT_US 1000
`define RWS_T_WAIT_US 95000
`define RWS_T_WATCH_US 8000
`define RWS_T_WDR_HOLD_US 2000
`define RWS_T_WAKE_US 1000
`endif

// file: rtl/rws_pkg.sv
// Types for the reset, watchdog and suspend sequencer
package rws_pkg;
  typedef enum logic [2:0] {
    SEQ_POR, SEQ_NOINT, SEQ_WAIT, SEQ_RUN, SEQ_WDR, SEQ_SUSPEND, SEQ_WAKE
  } rws_state_t;
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rws_iowr_t;
  typedef struct packed {
    logic cpuRun;
    logic vectorFetch;
    logic [13:0] vectorAddr;
    logic [7:0] stackInit;
  } rws_cpu_ctl_t;
endpackage

// file: rtl/rws_interval_timer.sv
// Down counter that pulses once when a loaded interval has run out
`timescale 1ns/1ps
`include "rws_params.svh"
module rws_interval_timer #(
  parameter int WIDTH = 22
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  input wire logic run,
  output logic expired
);
  initial begin
    if (WIDTH < 2 || WIDTH > 31) $error("rws_interval_timer: WIDTH out of range");
  end
  logic [WIDTH-1:0] count;
  logic active;
  wire lastTick = active && run && (count == {{(WIDTH-1){1'b0}}, 1'b1});
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count <= '0;
      active <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= lastTick;
      if (load) begin
        count <= loadValue;
        active <= 1'b1;
      end else if (active && run) begin
        count <= count - 1'b1;
        if (lastTick) active <= 1'b0;
      end
    end
  end
endmodule

// file: rtl/rws_reset_seq.sv
// Power-on, watchdog and suspend sequencer for the CPU core
//
// What this block does
// - Hold CPU during reset, semi-suspend, suspend and wake
// - Start semi-suspend timer when supply and oscillator good
// - First 1 ms uninterruptible, then 95 ms wait
// - Bus reset in wait starts CPU at 0x0000
// - Early bus reset stays pending until enabled
// - Supply drop reasserts reset and repeats sequence
// - Any write to 0x26 clears watchdog
// - Watchdog rolls over after at least 8 ms
// - Watchdog reset loads status with 01000001
// - Watchdog reset holds 2 ms, then vector
// - Watchdog reset clears USB device address
// - Suspend bit switches off all but wake logic
// - Suspend stops oscillator and both timers
// - Only GPIO interrupt or USB activity wakes
// - CPU resumes 1 ms after oscillator stable
// - Next instruction runs before pending interrupts
// - Any reset restores defaults and stack pointers
`timescale 1ns/1ps
`include "rws_params.svh"
module rws_reset_seq #(
  parameter int CLK_HZ = `RWS_CLK_HZ,
  parameter int T_NOINT_US = `RWS_T_NOINT_US,
  parameter int T_WAIT_US = `RWS_T_WAIT_US,
  parameter int T_WATCH_US = `RWS_T_WATCH_US,
  parameter int T_WDR_HOLD_US = `RWS_T_WDR_HOLD_US,
  parameter int T_WAKE_US = `RWS_T_WAKE_US
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic supplyGood,
  input wire logic oscStable,
  input wire logic usbBusReset,
  input wire logic usbActivity,
  input wire logic gpioIrqWake,
  input wire rws_pkg::rws_iowr_t ioBus,
  input wire logic cpuIntAck,
  output logic [7:0] ioRdata,
  output rws_pkg::rws_cpu_ctl_t cpuCtl,
  output logic busResetPending,
  output logic busResetIrqEnable,
  output logic usbAddrClear,
  output logic regsDefault,
  output logic irqHold,
  output logic oscEnable,
  output logic timersRun,
  output logic blocksPowered
);
  localparam longint CYC_NOINT = (longint'(CLK_HZ) * T_NOINT_US + 999999) / 1000000;
  localparam longint CYC_WAIT = (longint'(CLK_HZ) * T_WAIT_US + 999999) / 1000000;
  localparam longint CYC_WATCH = (longint'(CLK_HZ) * T_WATCH_US + 999999) / 1000000;
  localparam longint CYC_WDR = (longint'(CLK_HZ) * T_WDR_HOLD_US + 999999) / 1000000;
  localparam longint CYC_WAKE = (longint'(CLK_HZ) * T_WAKE_US + 999999) / 1000000;
  localparam int TW = 22;
  initial begin
    if (CYC_WAIT >= (64'd1 << TW) || CYC_WATCH >= (64'd1 << TW)) begin
      $error("rws_reset_seq: interval too long for timer width");
    end
    if (CYC_NOINT < 1 || CYC_WDR < 1 || CYC_WAKE < 1) $error("rws_reset_seq: zero interval");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [4:0] syncA;
  logic [4:0] syncB;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      syncA <= 5'h00;
      syncB <= 5'h00;
    end else begin
      syncA <= {supplyGood, oscStable, usbBusReset, usbActivity, gpioIrqWake};
      syncB <= syncA;
    end
  end
  wire sSupply = syncB[4];
  wire sOsc = syncB[3];
  wire sBusRst = syncB[2];
  wire sUsbAct = syncB[1];
  wire sGpio = syncB[0];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state and decode
  rws_pkg::rws_state_t state;
  rws_pkg::rws_state_t next_state;
  logic [7:0] psc;
  logic wdogExpired;
  logic seqExpired;
  logic [TW-1:0] seqLoadValue;
  logic seqLoad;

  // Oscillator loss only matters before release; suspend stops it on purpose
  wire porActive = !sSupply || ((state == rws_pkg::SEQ_POR) && !sOsc);
  wire wrWdog = ioBus.wrEn && (ioBus.addr == `RWS_ADDR_WDOG_RESTART);
  wire wrPsc = ioBus.wrEn && (ioBus.addr == `RWS_ADDR_PSC);
  wire wrBrIe = ioBus.wrEn && (ioBus.addr == `RWS_ADDR_BUSRST_IE);
  wire enterSuspend = wrPsc && ioBus.wdata[`RWS_PSC_SUSPEND] && ioBus.wdata[`RWS_PSC_RUN];
  wire wakeEvent = sGpio || sUsbAct;
  wire inRun = (state == rws_pkg::SEQ_RUN);
  wire wdogFire = inRun && wdogExpired;
  wire busRstCut = (state == rws_pkg::SEQ_WAIT) && sBusRst;

  always_comb begin
    next_state = state;
    case (state)
      rws_pkg::SEQ_POR: begin
        if (!porActive) next_state = rws_pkg::SEQ_NOINT;
      end
      rws_pkg::SEQ_NOINT: begin
        if (seqExpired) next_state = rws_pkg::SEQ_WAIT;
      end
      rws_pkg::SEQ_WAIT: begin
        if (busRstCut || seqExpired) next_state = rws_pkg::SEQ_RUN;
      end
      rws_pkg::SEQ_RUN: begin
        if (wdogFire) begin
          next_state = rws_pkg::SEQ_WDR;
        end else if (enterSuspend) begin
          next_state = rws_pkg::SEQ_SUSPEND;
        end
      end
      rws_pkg::SEQ_WDR: begin
        if (seqExpired) next_state = rws_pkg::SEQ_RUN;
      end
      rws_pkg::SEQ_SUSPEND: begin
        if (wakeEvent) next_state = rws_pkg::SEQ_WAKE;
      end
      rws_pkg::SEQ_WAKE: begin
        if (seqExpired) next_state = rws_pkg::SEQ_RUN;
      end
      default: next_state = rws_pkg::SEQ_POR;
    endcase
    if (porActive) next_state = rws_pkg::SEQ_POR;
  end

  // Load the shared interval timer on every entry into a timed state
  wire enterNoint = (state == rws_pkg::SEQ_POR) && (next_state == rws_pkg::SEQ_NOINT);
  wire enterWait = (state == rws_pkg::SEQ_NOINT) && (next_state == rws_pkg::SEQ_WAIT);
  wire enterWdr = (next_state == rws_pkg::SEQ_WDR) && (state != rws_pkg::SEQ_WDR);
  // Oscillator must be stable before the 1 ms wake interval counts
  wire enterWake = (state == rws_pkg::SEQ_WAKE) && !sOsc;
  assign seqLoad = enterNoint || enterWait || enterWdr || enterWake;
  assign seqLoadValue = enterNoint ? TW'(CYC_NOINT) :
                        enterWait ? TW'(CYC_WAIT) :
                        enterWdr ? TW'(CYC_WDR) : TW'(CYC_WAKE);

  ////////////////////////////////////////////////////////////////////////////
  // Timers
  rws_interval_timer #(.WIDTH(TW)) seqTimer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(seqLoad || (state == rws_pkg::SEQ_SUSPEND) || porActive),
    .loadValue(seqLoadValue),
    .run(1'b1),
    .expired(seqExpired)
  );

  // Held loaded while not running, so a clear or an idle period restarts it
  wire wdogLoad = wrWdog || !inRun || enterSuspend;
  rws_interval_timer #(.WIDTH(TW)) wdogTimer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(wdogLoad),
    .loadValue(TW'(CYC_WATCH)),
    .run(inRun),
    .expired(wdogExpired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status and control register, bus reset enable
  logic brPend;
  logic brIe;
  wire anyReset = porActive || wdogFire;
  wire [7:0] pscWrite = {psc[7:5], psc[`RWS_PSC_POR], ioBus.wdata[3:0]};
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      psc <= `RWS_PSC_POR_VALUE;
      brIe <= 1'b0;
      brPend <= 1'b0;
    end else begin
      if (porActive) begin
        psc <= `RWS_PSC_POR_VALUE;
        brIe <= 1'b0;
      end else if (wdogFire) begin
        psc <= `RWS_PSC_WDR_VALUE;
        brIe <= 1'b0;
      end else begin
        if (wrPsc) psc <= {pscWrite[7], 1'b0, pscWrite[5:4], 1'b0, pscWrite[2:0]};
        if (state == rws_pkg::SEQ_WAKE && seqExpired) psc[`RWS_PSC_SUSPEND] <= 1'b0;
        if (wrBrIe) brIe <= ioBus.wdata[`RWS_BUSRST_IE_BIT];
      end
      // A new bus reset wins over the acknowledge in the same cycle
      if (porActive) begin
        brPend <= 1'b0;
      end else if (busRstCut || (sBusRst && inRun)) begin
        brPend <= 1'b1;
      end else if (cpuIntAck) begin
        brPend <= 1'b0;
      end
    end
  end

  wire [7:0] rdMux = (ioBus.addr == `RWS_ADDR_PSC) ? psc :
                     (ioBus.addr == `RWS_ADDR_BUSRST_IE) ? {7'h00, brIe} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  wire runNext = (next_state == rws_pkg::SEQ_RUN) && !anyReset;
  wire vecNext = runNext && (state != rws_pkg::SEQ_RUN) &&
                 (state != rws_pkg::SEQ_WAKE);
  wire lowPower = (next_state == rws_pkg::SEQ_SUSPEND);
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state <= rws_pkg::SEQ_POR;
      ioRdata <= 8'h00;
      cpuCtl <= '0;
      busResetPending <= 1'b0;
      busResetIrqEnable <= 1'b0;
      usbAddrClear <= 1'b1;
      regsDefault <= 1'b1;
      irqHold <= 1'b1;
      oscEnable <= 1'b1;
      timersRun <= 1'b0;
      blocksPowered <= 1'b1;
    end else begin
      state <= next_state;
      ioRdata <= ioBus.rdEn ? rdMux : 8'h00;
      cpuCtl.cpuRun <= runNext;
      cpuCtl.vectorFetch <= vecNext;
      cpuCtl.vectorAddr <= `RWS_RESET_VECTOR;
      cpuCtl.stackInit <= `RWS_STACK_RESET;
      busResetPending <= brPend;
      busResetIrqEnable <= brIe;
      usbAddrClear <= anyReset || (state == rws_pkg::SEQ_WDR);
      regsDefault <= anyReset || (state == rws_pkg::SEQ_WDR);
      // Interrupts stay blocked until the instruction after suspend has run
      irqHold <= !runNext || (state == rws_pkg::SEQ_WAKE);
      oscEnable <= !lowPower;
      timersRun <= runNext;
      blocksPowered <= !lowPower;
    end
  end
endmodule

// file: verif/rws_reset_seq_asserts.sv
// Port assertions for the reset, watchdog and suspend sequencer
`timescale 1ns/1ps
module rws_reset_seq_asserts (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic supplyGood,
  input wire logic usbActivity,
  input wire logic gpioIrqWake,
  input wire rws_pkg::rws_iowr_t ioBus,
  input wire rws_pkg::rws_cpu_ctl_t cpuCtl,
  input wire logic busResetPending,
  input wire logic busResetIrqEnable,
  input wire logic usbAddrClear,
  input wire logic regsDefault,
  input wire logic irqHold,
  input wire logic oscEnable,
  input wire logic timersRun,
  input wire logic blocksPowered
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  vec_start_a: assert property (cpuCtl.vectorFetch |-> cpuCtl.cpuRun &&
    !$past(cpuCtl.cpuRun) && cpuCtl.vectorAddr == 14'h0000 && cpuCtl.stackInit == 8'h00)
    else $error("vector fetch without a clean start at zero");
  vec_pulse_a: assert property (cpuCtl.vectorFetch |=> !cpuCtl.vectorFetch)
    else $error("vector fetch longer than one cycle");
  susp_off_a: assert property (!oscEnable |-> !blocksPowered && !cpuCtl.cpuRun && !timersRun)
    else $error("logic alive while oscillator off");
  timer_gate_a: assert property (timersRun |-> cpuCtl.cpuRun)
    else $error("timer runs while cpu held");
  susp_entry_a: assert property (ioBus.wrEn && ioBus.addr == 8'hff && ioBus.wdata == 8'h09 &&
    cpuCtl.cpuRun |=> !oscEnable && !blocksPowered) else $error("suspend write not taken");
  wake_only_a: assert property ((supplyGood && !usbActivity && !gpioIrqWake)[*5] ##0 !oscEnable
    |=> !oscEnable) else $error("woke without a wake source");
  pend_hold_a: assert property (busResetPending && !busResetIrqEnable && supplyGood
    |=> busResetPending) else $error("bus reset pending lost while disabled");
  rst_state_a: assert property (disable iff (1'b0) !nrst |=> usbAddrClear && regsDefault &&
    irqHold && !cpuCtl.cpuRun) else $error("reset defaults not applied");
  resume_hold_a: assert property ($rose(cpuCtl.cpuRun) && !cpuCtl.vectorFetch |-> irqHold)
    else $error("interrupts open at resume");
  wdr_addr_a: assert property ($fell(cpuCtl.cpuRun) && oscEnable |-> ##[0:2] usbAddrClear)
    else $error("address not cleared on reset");
endmodule
bind rws_reset_seq rws_reset_seq_asserts u_asserts (.clk_sys, .nrst, .supplyGood, .usbActivity,
  .gpioIrqWake, .ioBus, .cpuCtl, .busResetPending, .busResetIrqEnable, .usbAddrClear,
  .regsDefault, .irqHold, .oscEnable, .timersRun, .blocksPowered);

// file: verif/rws_far_side.sv
// Model of supply monitor, oscillator and cpu interrupt acknowledge
`timescale 1ns/1ps
module rws_far_side #(
  parameter int OSC_SETTLE = 20
) (
  input wire logic clk_sys,
  input wire logic supplyOn,
  input wire logic oscEnable,
  input wire logic busResetPending,
  input wire logic busResetIrqEnable,
  output logic supplyGood,
  output logic oscStable = 1'b0,
  output logic cpuIntAck = 1'b0
);
  int settle = 0;
  assign supplyGood = supplyOn;
  // Stable only after a settle time, so wake timing is seen from stable, not enable
  always @(posedge clk_sys) begin
    #1;
    settle = (oscEnable && supplyOn) ? ((settle < OSC_SETTLE) ? settle + 1 : settle) : 0;
    oscStable = (settle == OSC_SETTLE);
    cpuIntAck = busResetPending && busResetIrqEnable && !cpuIntAck;
  end
endmodule

// file: verif/rws_reset_seq_tb_top.sv
// Self-checking testbench for the reset, watchdog and suspend sequencer
`timescale 1ns/1ps
module rws_reset_seq_tb_top;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic supplyOn = 1'b0;
  logic usbBusReset = 1'b0;
  logic usbActivity = 1'b0;
  logic gpioIrqWake = 1'b0;
  rws_pkg::rws_iowr_t ioBus = '0;
  logic supplyGood, oscStable, cpuIntAck, busResetPending, busResetIrqEnable, usbAddrClear;
  logic regsDefault, irqHold, oscEnable, timersRun, blocksPowered, vf;
  logic [7:0] ioRdata;
  rws_pkg::rws_cpu_ctl_t cpuCtl;
  int bad_count = 0;
  int n_checks = 0;
  int n;
  always #12.5 clk_sys = ~clk_sys;
  // Short intervals: 80 no-interrupt, 400 wait, 800 watchdog, 200 hold, 80 wake cycles
  rws_reset_seq #(.T_NOINT_US(2), .T_WAIT_US(10), .T_WATCH_US(20), .T_WDR_HOLD_US(5),
    .T_WAKE_US(2)) u_dut (.clk_sys, .nrst, .supplyGood, .oscStable, .usbBusReset, .usbActivity,
    .gpioIrqWake, .ioBus, .cpuIntAck, .ioRdata, .cpuCtl, .busResetPending, .busResetIrqEnable,
    .usbAddrClear, .regsDefault, .irqHold, .oscEnable, .timersRun, .blocksPowered);
  rws_far_side u_far (.clk_sys, .supplyOn, .oscEnable, .busResetPending, .busResetIrqEnable,
    .supplyGood, .oscStable, .cpuIntAck);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic range(input int lo, input int hi);
    chk(8'(n >= lo && n < hi), 8'h01);
  endtask
  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    ioBus = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
    step(1);
    ioBus = '0;
    step(1);
  endtask
  task automatic io_rd(input logic [7:0] a, input logic [7:0] exp);
    ioBus = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 8'h00};
    step(1);
    ioBus = '0;
    chk(ioRdata, exp);
    step(1);
  endtask
  task automatic wait_run(input int lim);
    n = 0;
    while (cpuCtl.cpuRun !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    vf = cpuCtl.vectorFetch;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    step(10);
    nrst = 1'b1;
    step(3);
    supplyOn = 1'b1;
    wait_run(1000);
    range(500, 515);
    chk(8'({vf, timersRun}), 8'h03);
    chk(8'({cpuCtl.vectorAddr == 14'h0000, cpuCtl.stackInit == 8'h00}), 8'h03);
    io_rd(8'hff, 8'h11);
    $display("power-on test done");
    supplyOn = 1'b0;
    step(5);
    chk(8'({cpuCtl.cpuRun, usbAddrClear}), 8'h01);
    supplyOn = 1'b1;
    step(40);
    usbBusReset = 1'b1;
    step(4);
    usbBusReset = 1'b0;
    step(150);
    chk(8'(cpuCtl.cpuRun), 8'h00);
    usbBusReset = 1'b1;
    wait_run(20);
    usbBusReset = 1'b0;
    step(1);
    chk(8'({vf, busResetPending}), 8'h03);
    step(20);
    chk(8'(busResetPending), 8'h01);
    io_wr(8'h20, 8'h01);
    step(5);
    chk(8'({busResetIrqEnable, busResetPending}), 8'h02);
    $display("bus reset test done");
    for (int i = 0; i < 3; i++) begin
      io_wr(8'h26, 8'(i));
      step(600);
    end
    chk(8'(cpuCtl.cpuRun), 8'h01);
    n = 0;
    while (cpuCtl.cpuRun === 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    range(195, 215);
    chk(8'({usbAddrClear, regsDefault}), 8'h03);
    wait_run(400);
    range(195, 215);
    chk(8'(vf), 8'h01);
    io_wr(8'h30, 8'h09);
    io_rd(8'hff, 8'h41);
    $display("watchdog test done");
    // Each pass parks longer than the watchdog span, so a running timer would show
    for (int i = 0; i < 2; i++) begin
      io_wr(8'h26, 8'h00);
      io_wr(8'hff, 8'h09);
      chk(8'({oscEnable, blocksPowered, timersRun}), 8'h00);
      step(900);
      chk(8'({oscEnable, cpuCtl.cpuRun}), 8'h00);
      {gpioIrqWake, usbActivity} = 2'(i + 1);
      wait_run(200);
      {gpioIrqWake, usbActivity} = 2'b00;
      range(95, 115);
      chk(8'({vf, irqHold}), 8'h01);
    end
    $display("suspend test done");
    end_sim();
  end
  initial begin
    #500us;
    bad_count++;
    end_sim();
  end
endmodule
